// file: rtl/bcr_pkg.sv
package bcr_pkg;

  // ----------------------------------------
  // configuration offsets (byte offsets)
  // ----------------------------------------
  localparam logic [7:0] BCR_OFS_IO_LIMIT_UPPER = 8'h32;
  localparam logic [7:0] BCR_OFS_CAP_PTR = 8'h34;
  localparam logic [7:0] BCR_OFS_INT_LINE = 8'h3C;
  localparam logic [7:0] BCR_OFS_INT_PIN = 8'h3D;
  localparam logic [7:0] BCR_OFS_BRIDGE_CTRL = 8'h3E;

  // ----------------------------------------
  // reset and fixed values
  // ----------------------------------------
  localparam logic [15:0] BCR_RST_IO_LIMIT_UPPER = 16'h0000;
  localparam logic [7:0] BCR_VAL_CAP_PTR = 8'h50;
  localparam logic [7:0] BCR_RST_INT_LINE = 8'hFF;
  localparam logic [7:0] BCR_VAL_INT_PIN = 8'h00;
  localparam logic [15:0] BCR_RST_BRIDGE_CTRL = 16'h0000;
  localparam logic [19:0] BCR_IO_LIMIT_LOW_ONES = 20'hFFFFF;

  // ----------------------------------------
  // bridge control fields
  // ----------------------------------------
  localparam int BCR_BIT_DT_MSG_EN = 11;
  localparam int BCR_BIT_DT_FLAG = 10;
  localparam int BCR_BIT_DT_PERIOD = 9;

  // ----------------------------------------
  // discard timer periods, in pci clocks
  // ----------------------------------------
  localparam int BCR_DT_LONG_EXP = 15;
  localparam int BCR_DT_SHORT_EXP = 10;
  localparam int BCR_DT_LONG_CYC = 2 ** BCR_DT_LONG_EXP;
  localparam int BCR_DT_SHORT_CYC = 2 ** BCR_DT_SHORT_EXP;
  localparam int BCR_DT_CNT_W = 16;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] dw_addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bcr_cfg_req_t;

  typedef struct packed {
    logic valid;
    logic fatal;
  } bcr_err_msg_t;

  typedef enum logic {
    BCR_DT_IDLE,
    BCR_DT_COUNT
  } bcr_dt_state_t;

endpackage

// file: rtl/bcr_regs.sv
`timescale 1ns/1ns
// How it works
// R1 - io limit upper 16 bits, rw, steers forwarding
// R2 - limit low twenty address bits read as ones
// R3 - capability pointer hardwired to 50h
// R4 - interrupt line rw, resets to FFh
// R5 - interrupt line stored only, drives nothing
// R6 - interrupt pin reads zero always
// R7 - secondary interrupts forwarded to primary side
// R8 - control bits 15:12 read zero, ignore writes
// R9 - bit 11 message enable rw, conventional mode only
// R10 - enabled expiry sends error message upstream
// R11 - nonfatal default, fatal only with aer
// R12 - enable clear: message only via aer mask
// R13 - bit 10 flags discarded delayed transaction
// R14 - flag write-one-clear, event beats clear
// R15 - bit 9 selects 2^15 or 2^10 clocks
module bcr_regs #(
  parameter int DT_LONG_CYC = bcr_pkg::BCR_DT_LONG_CYC,
  parameter int DT_SHORT_CYC = bcr_pkg::BCR_DT_SHORT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // configuration access
  input bcr_pkg::bcr_cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // io window check
  input wire logic [35:0] io_addr,
  output logic io_in_limit,
  // delayed transaction discard timer
  input wire logic dc_at_head,
  input wire logic master_repeated,
  output logic dt_discard,
  // error messaging
  input wire logic conv_pci_mode,
  input wire logic aer_present,
  input wire logic aer_sev_fatal,
  input wire logic aer_dt_mask,
  output bcr_pkg::bcr_err_msg_t err_msg,
  // interrupt pass-through
  input wire logic [3:0] sec_intx_n,
  output logic [3:0] pri_intx_n
);
  import bcr_pkg::*;

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (DT_SHORT_CYC < 2 || DT_LONG_CYC < 2 || DT_LONG_CYC > 2 ** BCR_DT_CNT_W - 1 ||
      DT_SHORT_CYC > 2 ** BCR_DT_CNT_W - 1) begin : g_bad_period
    $error("discard timer period out of range");
  end

  localparam logic [BCR_DT_CNT_W-1:0] DT_CNT_ONE = BCR_DT_CNT_W'(1);
  localparam logic [BCR_DT_CNT_W-1:0] DT_LONG_LD = BCR_DT_CNT_W'(DT_LONG_CYC);
  localparam logic [BCR_DT_CNT_W-1:0] DT_SHORT_LD = BCR_DT_CNT_W'(DT_SHORT_CYC);
  localparam logic [5:0] DW_IO = BCR_OFS_IO_LIMIT_UPPER[7:2];
  localparam logic [5:0] DW_CAP = BCR_OFS_CAP_PTR[7:2];
  localparam logic [5:0] DW_INT = BCR_OFS_INT_LINE[7:2];

  logic [15:0] io_limit_q;
  logic [7:0] int_line_q;
  logic dt_msg_en_q;
  logic dt_flag_q;
  logic dt_period_q;
  logic [15:0] ctrl_rd;
  logic wr_io;
  logic wr_int;
  logic expire;
  bcr_dt_state_t dt_state_q;
  logic [BCR_DT_CNT_W-1:0] dt_cnt_q;
  logic [3:0] intx_s1_q;
  logic [3:0] intx_s2_q;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  assign wr_io = cfg_req.wr && cfg_req.dw_addr == DW_IO;
  assign wr_int = cfg_req.wr && cfg_req.dw_addr == DW_INT;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      io_limit_q <= BCR_RST_IO_LIMIT_UPPER;
    end else if (wr_io) begin
      if (cfg_req.be[2]) io_limit_q[7:0] <= cfg_req.wdata[23:16]; // R1
      if (cfg_req.be[3]) io_limit_q[15:8] <= cfg_req.wdata[31:24]; // R1
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      int_line_q <= BCR_RST_INT_LINE; // R4
    end else if (wr_int && cfg_req.be[0]) begin
      int_line_q <= cfg_req.wdata[7:0]; // R4 R5
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dt_msg_en_q <= BCR_RST_BRIDGE_CTRL[BCR_BIT_DT_MSG_EN];
      dt_period_q <= BCR_RST_BRIDGE_CTRL[BCR_BIT_DT_PERIOD];
    end else if (wr_int) begin
      if (cfg_req.be[3]) dt_msg_en_q <= cfg_req.wdata[16 + BCR_BIT_DT_MSG_EN]; // R9
      if (cfg_req.be[3]) dt_period_q <= cfg_req.wdata[16 + BCR_BIT_DT_PERIOD]; // R15
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dt_flag_q <= BCR_RST_BRIDGE_CTRL[BCR_BIT_DT_FLAG];
    end else if (expire) begin
      dt_flag_q <= 1'b1; // R13 R14
    end else if (wr_int && cfg_req.be[3] && cfg_req.wdata[16 + BCR_BIT_DT_FLAG]) begin
      dt_flag_q <= 1'b0; // R14
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always_comb begin
    ctrl_rd = 16'h0000; // R8
    ctrl_rd[BCR_BIT_DT_MSG_EN] = dt_msg_en_q;
    ctrl_rd[BCR_BIT_DT_FLAG] = dt_flag_q; // R13
    ctrl_rd[BCR_BIT_DT_PERIOD] = dt_period_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_req.rd;
      if (cfg_req.rd) begin
        case (cfg_req.dw_addr)
          DW_IO: cfg_rdata <= {io_limit_q, 16'h0000};
          DW_CAP: cfg_rdata <= {24'h000000, BCR_VAL_CAP_PTR}; // R3
          DW_INT: cfg_rdata <= {ctrl_rd, BCR_VAL_INT_PIN, int_line_q}; // R6
          default: cfg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // io window limit check
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      io_in_limit <= 1'b0;
    end else begin
      io_in_limit <= io_addr <= {io_limit_q, BCR_IO_LIMIT_LOW_ONES}; // R1 R2
    end
  end

  // ----------------------------------------
  // discard timer
  // ----------------------------------------
  assign expire = dt_state_q == BCR_DT_COUNT && !master_repeated && dt_cnt_q == DT_CNT_ONE;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dt_state_q <= BCR_DT_IDLE;
      dt_cnt_q <= 16'h0000;
    end else begin
      case (dt_state_q)
        BCR_DT_IDLE: begin
          if (dc_at_head) begin
            dt_state_q <= BCR_DT_COUNT;
            dt_cnt_q <= dt_period_q ? DT_SHORT_LD : DT_LONG_LD; // R15
          end
        end
        BCR_DT_COUNT: begin
          if (master_repeated || expire) begin
            dt_state_q <= BCR_DT_IDLE; // R15
          end
          dt_cnt_q <= dt_cnt_q - DT_CNT_ONE;
        end
        default: dt_state_q <= BCR_DT_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dt_discard <= 1'b0;
    end else begin
      dt_discard <= expire; // R15
    end
  end

  // ----------------------------------------
  // error message on expiry
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      err_msg <= '0;
    end else begin
      err_msg.valid <= expire && ((dt_msg_en_q && conv_pci_mode) || (aer_present && !aer_dt_mask)); // R9 R10 R12
      err_msg.fatal <= aer_present && aer_sev_fatal; // R11
    end
  end

  // ----------------------------------------
  // interrupt pass-through
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      intx_s1_q <= 4'hF;
      intx_s2_q <= 4'hF;
      pri_intx_n <= 4'hF;
    end else begin
      intx_s1_q <= sec_intx_n;
      intx_s2_q <= intx_s1_q;
      pri_intx_n <= intx_s2_q; // R7
    end
  end

endmodule // bcr_regs

// file: test/bcr_host.sv
`timescale 1ns/1ns
module bcr_host (
  // clock
  input wire logic sys_clk,
  // config port
  output bcr_pkg::bcr_cfg_req_t cfg_req,
  input wire logic [31:0] cfg_rdata
);
  import bcr_pkg::*;
  initial cfg_req = '0;
  // one access, held over one edge
  task automatic acc(input logic w, input logic [5:0] a, input logic [3:0] be, input logic [31:0] d,
    output logic [31:0] q);
    @(negedge sys_clk);
    cfg_req = '{wr: w, rd: !w, dw_addr: a, be: be, wdata: d};
    @(negedge sys_clk);
    q = cfg_rdata;
    cfg_req = '0;
  endtask
endmodule // bcr_host

// file: test/bcr_regs_assertions.sv
`timescale 1ns/1ns
module bcr_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // watched ports
  input bcr_pkg::bcr_cfg_req_t cfg_req,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic dt_discard,
  input wire logic aer_present,
  input wire logic aer_sev_fatal,
  input wire logic aer_dt_mask,
  input bcr_pkg::bcr_err_msg_t err_msg,
  input wire logic [3:0] sec_intx_n,
  input wire logic [3:0] pri_intx_n
);
  import bcr_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_cap_ptr_fixed: assert property (cfg_req.rd && cfg_req.dw_addr == 6'h0D |=> cfg_rdata == 32'h00000050)
    else $error("cap pointer wrong");
  a_pin_reads_zero: assert property (cfg_req.rd && cfg_req.dw_addr == 6'h0F |=> cfg_rdata[15:8] == 8'h00)
    else $error("int pin not zero");
  a_ctrl_rsvd_zero: assert property (cfg_req.rd && cfg_req.dw_addr == 6'h0F |=> cfg_rdata[31:28] == 4'h0)
    else $error("reserved bits set");
  a_read_answer: assert property ($past(rst_n) |-> cfg_rvalid == $past(cfg_req.rd))
    else $error("read answer timing");
  a_intx_forward: assert property ($past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n) |->
    pri_intx_n == $past(sec_intx_n, 3)) else $error("intx not forwarded");
  a_msg_on_discard: assert property (err_msg.valid |-> dt_discard) else $error("stray message");
  a_msg_aer_path: assert property (dt_discard && $past(aer_present) && !$past(aer_dt_mask) |-> err_msg.valid)
    else $error("aer message missing");
  a_msg_severity: assert property (err_msg.valid |->
    err_msg.fatal == ($past(aer_present) && $past(aer_sev_fatal))) else $error("message severity");
  a_discard_single: assert property (dt_discard |=> !dt_discard) else $error("discard not a pulse");
  c_discard: cover property (dt_discard);
  c_fatal: cover property (err_msg.valid && err_msg.fatal);
  c_read: cover property (cfg_rvalid);
endmodule // bcr_chk
bind bcr_regs bcr_chk bcr_chk_i (.sys_clk, .rst_n, .cfg_req, .cfg_rdata, .cfg_rvalid, .dt_discard,
  .aer_present, .aer_sev_fatal, .aer_dt_mask, .err_msg, .sec_intx_n, .pri_intx_n);

// file: test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import bcr_pkg::*;
  logic sys_clk, rst_n, cfg_rvalid, io_in_limit, dc_at_head, master_repeated, dt_discard;
  logic conv_pci_mode, aer_present, aer_sev_fatal, aer_dt_mask;
  logic [35:0] io_addr;
  logic [31:0] cfg_rdata, q;
  logic [3:0] sec_intx_n, pri_intx_n;
  logic [7:0] line;
  logic [15:0] lim;
  bcr_cfg_req_t cfg_req;
  bcr_err_msg_t err_msg;
  int n_errors, tests_run;
  bcr_regs #(.DT_LONG_CYC(40), .DT_SHORT_CYC(8)) bcr_regs_i (.sys_clk, .rst_n, .cfg_req, .cfg_rdata,
    .cfg_rvalid, .io_addr, .io_in_limit, .dc_at_head, .master_repeated, .dt_discard, .conv_pci_mode,
    .aer_present, .aer_sev_fatal, .aer_dt_mask, .err_msg, .sec_intx_n, .pri_intx_n);
  bcr_host bcr_host_i (.sys_clk, .cfg_req, .cfg_rdata);
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] r;
    bcr_host_i.acc(0, a, 4'hF, 32'h0, r);
    chk(cfg_rvalid, 1);
    chk(r, e);
  endtask
  // discard run: control, aer, severity, mask, abort
  task automatic dt_run(input logic [15:0] c, input logic a, input logic f, input logic m, input logic ab);
    int k;
    int n;
    n = c[9] ? 8 : 40;
    bcr_host_i.acc(1, 6'h0F, 4'hC, {c, 16'h0}, q);
    aer_present = a;
    aer_sev_fatal = f;
    aer_dt_mask = m;
    dc_at_head = 1;
    @(negedge sys_clk);
    dc_at_head = 0;
    for (k = 1; k < 60 && !dt_discard; k++) begin
      master_repeated = ab && k == 3;
      @(negedge sys_clk);
    end
    chk(k, ab ? 60 : n + 1);
    chk({err_msg.valid, err_msg.fatal}, ab ? 2'b00 : {(c[11] && conv_pci_mode) || (a && !m), a && f});
    if (k == 60 && !ab) stop_test();
    rdc(6'h0F, {c & 16'h0A00 | (ab ? 16'h0 : 16'h0400), 8'h00, line});
  endtask
  initial begin
    void'($urandom(59227));
    {rst_n, io_addr, dc_at_head, master_repeated, aer_present, aer_sev_fatal, aer_dt_mask} = '0;
    conv_pci_mode = 1;
    sec_intx_n = 4'hF;
    n_errors = 0;
    tests_run = 0;
    repeat (8) @(negedge sys_clk);
    rst_n = 1;
    rdc(6'h0C, 32'h0);
    rdc(6'h0D, 32'h50);
    rdc(6'h0F, 32'hFF);
    line = 8'($urandom);
    bcr_host_i.acc(1, 6'h0D, 4'hF, 32'hFFFFFFFF, q);
    bcr_host_i.acc(1, 6'h0F, 4'h3, {16'hFFFF, 8'hFF, line}, q);
    rdc(6'h0D, 32'h50);
    rdc(6'h0F, {24'h0, line});
    rdc(6'h3F, 32'h0);
    for (int i = 0; i < 3; i++) begin
      lim = (i == 0) ? 16'h0000 : 16'($urandom % 16'hFFFF);
      bcr_host_i.acc(1, 6'h0C, 4'hC, {lim, 16'h0}, q);
      rdc(6'h0C, {lim, 16'h0});
      io_addr = {lim, 20'hFFFFF};
      @(negedge sys_clk);
      chk(io_in_limit, 1);
      io_addr = io_addr + 1;
      @(negedge sys_clk);
      chk(io_in_limit, 0);
    end
    sec_intx_n = 4'($urandom) & 4'hE;
    repeat (4) @(negedge sys_clk);
    chk(pri_intx_n, sec_intx_n);
    dt_run(16'h0C00, 0, 1'($urandom), 0, 0);
    conv_pci_mode = 0;
    dt_run(16'h0C00, 0, 0, 0, 0);
    conv_pci_mode = 1;
    dt_run(16'h0200, 1, 1, 0, 0);
    dt_run(16'h0E00, 0, 0, 0, 1);
    dt_run(16'h0600, 1, 1, 1, 0);
    bcr_host_i.acc(1, 6'h0F, 4'hC, 32'hF0000000, q);
    rdc(6'h0F, {16'h0400, 8'h00, line});
    bcr_host_i.acc(1, 6'h0F, 4'hC, 32'h04000000, q);
    rdc(6'h0F, {16'h0000, 8'h00, line});
    bcr_host_i.acc(1, 6'h0F, 4'hC, 32'h02000000, q);
    dc_at_head = 1;
    @(negedge sys_clk);
    dc_at_head = 0;
    repeat (6) @(negedge sys_clk);
    bcr_host_i.acc(1, 6'h0F, 4'hC, 32'h06000000, q);
    chk(dt_discard, 1);
    rdc(6'h0F, {16'h0600, 8'h00, line});
    stop_test();
  end
endmodule // tb_top
